// >>> bench/mmc_ctrl_tb.sv
// self-checking bench for the module management control block
`timescale 1ns/10ps
`default_nettype none
module mmc_ctrl_tb;
  localparam int INIT = 50;
  localparam int WAKE = 20;
  logic               clk, rst_b, mrst_n, lpr, pcn, lk_clk, rd_done, wr_done;
  logic               int_n, dnr, bus_rdy, ff, pl1;
  logic [11:0]        cond, mask;
  logic [12:0]        rd_flags, flags;
  logic [3:0]         rsel;
  mmc_pkg::mmc_ctrl_t wr_data;
  int                 error_cnt = 0;
  int                 checked = 0;
  int                 t;
  // condition pins beside the flag vector they must raise
  logic [24:0]        rows [4] = '{{12'h001, 13'h0001}, {12'h008, 13'h0008}, {12'h020, 13'h0020}, {12'h400, 13'h0400}};

  mmc_host_model i_mmc_host_model (.o_link_clk(lk_clk), .o_rd_done(rd_done), .o_rd_flags(rd_flags),
    .o_wr_done(wr_done), .o_wr_data(wr_data));
  mmc_ctrl #(.INIT_CYC(INIT), .WAKE_CYC(WAKE)) i_mmc_ctrl (.i_clock(clk), .i_rst_b(rst_b),
    .i_module_reset_n(mrst_n), .i_low_power_request(lpr), .i_power_class_nonzero(pcn),
    .i_rx_los(cond[3:0]), .i_tx_fault(cond[7:4]), .i_other_cond(cond[11:8]), .i_link_clk(lk_clk),
    .i_lk_rd_done(rd_done), .i_lk_rd_flags(rd_flags), .i_lk_wr_done(wr_done), .i_lk_wr_data(wr_data),
    .o_interrupt_n(int_n), .o_data_not_ready(dnr), .o_bus_ready(bus_rdy), .o_fully_functional(ff),
    .o_power_level1(pl1), .o_flags(flags), .o_mask(mask), .o_rate_sel(rsel));

  // sample just after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bounded wait on data-not-ready (s=0) or fully functional (s=1)
  task automatic await(input int s, input logic v, input int n);
    for (t = 0; t < n && (s == 0 ? dnr : ff) !== v; t++) tick(1);
    if ((s == 0 ? dnr : ff) !== v) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, !v, v);
      give_verdict();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    mrst_n = 1'b1;
    lpr = 1'b0;
    pcn = 1'b0;
    cond = 12'h000;
    tick(2);
    chk({int_n, dnr, bus_rdy, ff, pl1}, 16'h0018);
    chk(flags, 16'h0000);
    chk({mask, rsel}, 16'h0000);
    @(posedge clk) rst_b <= 1'b1;
    await(0, 1'b0, INIT + 10);
    chk({bus_rdy, flags}, 16'h3000);
    tick(1);
    chk(int_n, 16'h0000);
    tick(1);
    chk(ff, 16'h0001);
    i_mmc_host_model.frame(1, 17'h01000);
    tick(12);
    chk({int_n, flags}, 16'h2000);
    $display("test done: reset and init");
    for (int r = 0; r < 4; r++) begin
      @(posedge clk) cond <= rows[r][24:13];
      tick(5);
      chk({int_n, flags}, {3'h0, rows[r][12:0]});
      i_mmc_host_model.frame(1, {4'h0, rows[r][12:0]});
      tick(12);
      chk({int_n, flags}, 16'h2000);
      @(posedge clk) cond <= 12'h000;
    end
    $display("test done: flag rows");
    // two flags up: clearing one must leave the interrupt asserted
    @(posedge clk) cond <= 12'h011;
    tick(5);
    i_mmc_host_model.frame(1, 17'h00001);
    tick(12);
    chk({int_n, flags}, 16'h0010);
    i_mmc_host_model.frame(1, 17'h00010);
    tick(12);
    chk({int_n, flags}, 16'h2000);
    @(posedge clk) cond <= 12'h000;
    $display("test done: two flags");
    i_mmc_host_model.frame(0, {12'h001, 4'h0, 1'b0});
    tick(12);
    chk(mask, 16'h0001);
    @(posedge clk) cond <= 12'h001;
    tick(5);
    chk({int_n, flags}, 16'h2001);
    i_mmc_host_model.frame(0, 17'h00000);
    tick(12);
    chk({int_n, mask}, 16'h0000);
    i_mmc_host_model.frame(1, 17'h00001);
    @(posedge clk) cond <= 12'h000;
    tick(12);
    chk({int_n, flags}, 16'h2000);
    $display("test done: mask");
    i_mmc_host_model.frame(0, {12'h000, 4'hA, 1'b1});
    tick(12);
    chk({int_n, rsel, pl1, ff}, 16'h006A);
    i_mmc_host_model.frame(0, {12'h000, 4'h5, 1'b0});
    await(1, 1'b1, WAKE + 20);
    chk({rsel, pl1}, 16'h000A);
    $display("test done: override and rate");
    @(posedge clk) lpr <= 1'b1;
    tick(4);
    chk({pl1, ff}, 16'h0002);
    @(posedge clk) lpr <= 1'b0;
    tick(4);
    chk({pl1, ff}, 16'h0000);
    await(1, 1'b1, WAKE + 4);
    $display("test done: low power pin");
    // a low shorter than the minimum pulse must be ignored
    @(posedge clk) mrst_n <= 1'b0;
    tick(60);
    @(posedge clk) mrst_n <= 1'b1;
    tick(8);
    chk({dnr, ff}, 16'h0001);
    @(posedge clk) begin
      mrst_n <= 1'b0;
      pcn <= 1'b1;
      lpr <= 1'b1;
    end
    tick(90);
    chk({dnr, ff}, 16'h0002);
    @(posedge clk) mrst_n <= 1'b1;
    tick(INIT + 20);
    chk(dnr, 16'h0001);
    @(posedge clk) lpr <= 1'b0;
    await(0, 1'b0, INIT + 10);
    await(1, 1'b1, WAKE + 10);
    $display("test done: host reset");
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> bench/mmc_host_model.sv
// host controller model: drives the serial engine side of the link clock domain
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
  // link clock, idles high between frames
  output logic               o_link_clk,
  // completed transfers
  output logic               o_rd_done,
  output logic [12:0]        o_rd_flags,
  output logic               o_wr_done,
  output mmc_pkg::mmc_ctrl_t o_wr_data
);
  initial begin
    o_link_clk = 1'b1;
    o_rd_done  = 1'b0;
    o_rd_flags = 13'h0000;
    o_wr_done  = 1'b0;
    o_wr_data  = 17'h00000;
  end
  // one frame of six 30 ns link clocks; done is held across the falling edge after stop
  task automatic frame(input bit rd, input logic [16:0] v);
    for (int k = 0; k < 6; k++) begin
      #15 o_link_clk = 1'b0;
      #1;
      o_rd_done = rd && k == 2;
      o_wr_done = !rd && k == 2;
      if (k == 2 && rd) o_rd_flags = v[12:0];
      if (k == 2 && !rd) o_wr_data = v;
      // released data is inverted so a stale value can never look valid
      if (k == 3) o_rd_flags = ~o_rd_flags;
      if (k == 3) o_wr_data = ~o_wr_data;
      #14 o_link_clk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// >>> shared/mmc_consts.svh
// timing counts, widths and reset values of the module management control block
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH
`define MMC_CLK_NS       25
`define MMC_T_RST_MIN_NS 2000
`define MMC_RST_MIN_CYC  ((`MMC_T_RST_MIN_NS + `MMC_CLK_NS - 1) / `MMC_CLK_NS)
`define MMC_T_INIT_MS    2000
`define MMC_T_WAKE_MS    300
`define MMC_MS_CYC(ms)   ((ms) * (1000000 / `MMC_CLK_NS))
`define MMC_NLANE        4
`define MMC_NOTHER       4
`define MMC_FLAG_W       13
`define MMC_FLAG_LOS     0
`define MMC_FLAG_FAULT   4
`define MMC_FLAG_OTHER   8
`define MMC_FLAG_INIT    12
`define MMC_MASK_RST     12'h000
`define MMC_RSEL_RST     4'h0
`endif

// >>> shared/mmc_pkg.sv
// types shared by the module management control block
package mmc_pkg;
  // control word carried by a completed serial write
  typedef struct packed {
    logic [11:0] mask;
    logic [3:0]  rate_sel;
    logic        pdown;
  } mmc_ctrl_t;
  typedef enum logic [0:0] {ST_INIT, ST_READY} mmc_state_t;
endpackage

// >>> src/mmc_ctrl.sv
// management control, status and interrupt timing of a four-lane optical module
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.svh"
module mmc_ctrl #(
  parameter int INIT_CYC = `MMC_MS_CYC(`MMC_T_INIT_MS),
  parameter int WAKE_CYC = `MMC_MS_CYC(`MMC_T_WAKE_MS)
) (
  // core clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_b,
  // host control pins
  input  wire logic                    i_module_reset_n,
  input  wire logic                    i_low_power_request,
  input  wire logic                    i_power_class_nonzero,
  // optics condition pins
  input  wire logic [`MMC_NLANE-1:0]   i_rx_los,
  input  wire logic [`MMC_NLANE-1:0]   i_tx_fault,
  input  wire logic [`MMC_NOTHER-1:0]  i_other_cond,
  // serial engine, link clock domain
  input  wire logic                    i_link_clk,
  input  wire logic                    i_lk_rd_done,
  input  wire logic [`MMC_FLAG_W-1:0]  i_lk_rd_flags,
  input  wire logic                    i_lk_wr_done,
  input  wire mmc_pkg::mmc_ctrl_t      i_lk_wr_data,
  // status
  output logic                         o_interrupt_n,
  output logic                         o_data_not_ready,
  output logic                         o_bus_ready,
  output logic                         o_fully_functional,
  output logic                         o_power_level1,
  output logic [`MMC_FLAG_W-1:0]       o_flags,
  output logic [11:0]                  o_mask,
  output logic [3:0]                   o_rate_sel
);
  localparam int CW = $clog2(INIT_CYC + WAKE_CYC + 2);
  localparam int RW = $clog2(`MMC_RST_MIN_CYC + 1);
  localparam logic [RW-1:0] RST_MIN = RW'(`MMC_RST_MIN_CYC);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // rising edge of a synchronised vector
  function automatic logic [11:0] rise12(input logic [11:0] now, input logic [11:0] was);
    rise12 = now & ~was;
  endfunction

  // link side: capture on the falling edge after the stop bit, then toggle
  logic                    rd_tgl_reg;
  logic                    wr_tgl_reg;
  logic [`MMC_FLAG_W-1:0]  rd_hold_reg;
  mmc_pkg::mmc_ctrl_t      wr_hold_reg;
  always_ff @(negedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_tgl_reg  <= 1'b0;
      rd_hold_reg <= '0;
    end else if (i_lk_rd_done) begin
      rd_hold_reg <= i_lk_rd_flags;
      rd_tgl_reg  <= ~rd_tgl_reg;
    end
  end

  // hold words stay still until the next transaction, so the core samples them safely
  always_ff @(negedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_tgl_reg  <= 1'b0;
      wr_hold_reg <= '0;
    end else if (i_lk_wr_done) begin
      wr_hold_reg <= i_lk_wr_data;
      wr_tgl_reg  <= ~wr_tgl_reg;
    end
  end

  // toggle synchronisers; third stage feeds the edge detect
  logic [2:0] rd_sync_reg;
  logic [2:0] wr_sync_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_sync_reg <= 3'h0;
      wr_sync_reg <= 3'h0;
    end else begin
      rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
    end
  end
  logic rd_evt;
  logic wr_evt;
  assign rd_evt = rd_sync_reg[2] ^ rd_sync_reg[1];
  assign wr_evt = wr_sync_reg[2] ^ wr_sync_reg[1];

  // pin synchronisers; reset pin idles high so it resets to one
  logic [1:0]  rpin_sync_reg;
  logic [1:0]  lp_sync_reg;
  logic [11:0] cond_s1_reg;
  logic [11:0] cond_s2_reg;
  logic [11:0] cond_d_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rpin_sync_reg <= 2'h3;
      lp_sync_reg   <= 2'h0;
      cond_s1_reg   <= 12'h000;
      cond_s2_reg   <= 12'h000;
      cond_d_reg    <= 12'h000;
    end else begin
      rpin_sync_reg <= {rpin_sync_reg[0], i_module_reset_n};
      lp_sync_reg   <= {lp_sync_reg[0], i_low_power_request};
      cond_s1_reg   <= {i_other_cond, i_tx_fault, i_rx_los};
      cond_s2_reg   <= cond_s1_reg;
      cond_d_reg    <= cond_s2_reg;
    end
  end
  logic rpin_s;
  logic lp_s;
  assign rpin_s = rpin_sync_reg[1];
  assign lp_s   = lp_sync_reg[1];

  // reset pin pulse filter: short glitches never restart the module
  logic [RW-1:0] rlow_cnt_reg;
  logic          rst_held_reg;
  logic          rst_rise;
  assign rst_rise = rpin_s && rst_held_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rlow_cnt_reg <= '0;
      rst_held_reg <= 1'b0;
    end else if (rpin_s) begin
      rlow_cnt_reg <= '0;
      rst_held_reg <= 1'b0;
    end else if (rlow_cnt_reg == RST_MIN) begin
      rst_held_reg <= 1'b1;
    end else begin
      rlow_cnt_reg <= rlow_cnt_reg + RW'(1);
    end
  end

  // control word written over the serial bus
  mmc_pkg::mmc_ctrl_t ctrl_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg.mask     <= `MMC_MASK_RST;
      ctrl_reg.rate_sel <= `MMC_RSEL_RST;
      ctrl_reg.pdown    <= 1'b0;
    end else if (wr_evt) begin
      ctrl_reg <= wr_hold_reg;
    end
  end
  assign o_mask     = ctrl_reg.mask;
  assign o_rate_sel = ctrl_reg.rate_sel;

  // power level: low-power pin or override drop at once, wake takes a timer
  logic          pwr_low_reg;
  logic [CW-1:0] wake_cnt_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_low_reg  <= 1'b0;
      wake_cnt_reg <= '0;
    end else begin
      pwr_low_reg <= lp_s || ctrl_reg.pdown;
      if (pwr_low_reg && !(lp_s || ctrl_reg.pdown))
        wake_cnt_reg <= CW'(WAKE_CYC);
      else if (wake_cnt_reg != '0)
        wake_cnt_reg <= wake_cnt_reg - CW'(1);
    end
  end
  assign o_power_level1 = pwr_low_reg;

  // initialisation sequencer, restarted by a filtered reset pulse
  mmc_pkg::mmc_state_t state_reg;
  logic [CW-1:0]       init_cnt_reg;
  logic                init_stall;
  logic                init_done;
  assign init_stall = i_power_class_nonzero && pwr_low_reg;
  assign init_done  = state_reg == mmc_pkg::ST_INIT && init_cnt_reg == '0 && !rst_held_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg    <= mmc_pkg::ST_INIT;
      init_cnt_reg <= CW'(INIT_CYC - 1);
    end else if (rst_held_reg) begin
      state_reg    <= mmc_pkg::ST_INIT;
      init_cnt_reg <= CW'(INIT_CYC - 1);
    end else begin
      unique case (state_reg)
        mmc_pkg::ST_INIT: begin
          if (init_cnt_reg == '0)
            state_reg <= mmc_pkg::ST_READY;
          else if (!init_stall)
            init_cnt_reg <= init_cnt_reg - CW'(1);
        end
        mmc_pkg::ST_READY: begin
          state_reg <= mmc_pkg::ST_READY;
        end
      endcase
    end
  end
  assign o_data_not_ready = state_reg == mmc_pkg::ST_INIT;
  assign o_bus_ready      = state_reg == mmc_pkg::ST_READY;

  // sticky flags; a set in the cycle of a clearing read wins
  logic [`MMC_FLAG_W-1:0] flags_reg;
  logic [`MMC_FLAG_W-1:0] flag_set;
  logic [`MMC_FLAG_W-1:0] flag_clr;
  assign flag_set = {init_done, rise12(cond_s2_reg, cond_d_reg)};
  assign flag_clr = rd_evt ? rd_hold_reg : '0;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b)
      flags_reg <= '0;
    else if (rst_held_reg)
      flags_reg <= '0;
    else
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
  end
  assign o_flags = flags_reg;

  // interrupt: data-ready flag is never masked
  logic [`MMC_FLAG_W-1:0] irq_en;
  logic                   irq_any;
  assign irq_en  = {1'b1, ~ctrl_reg.mask};
  assign irq_any = |(flags_reg & irq_en);
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b)
      o_interrupt_n <= 1'b1;
    else
      o_interrupt_n <= ~irq_any;
  end

  // fully functional once the data-ready interrupt has been raised, while out of low power and the wake timer has run out
  logic init_seen_reg;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b)
      init_seen_reg <= 1'b0;
    else if (rst_held_reg)
      init_seen_reg <= 1'b0;
    else if (flags_reg[`MMC_FLAG_INIT] && !o_interrupt_n)
      init_seen_reg <= 1'b1;
  end
  assign o_fully_functional = init_seen_reg && !pwr_low_reg && wake_cnt_reg == '0;

  // checks
  // pin back high while still held, then the held state drops one edge later
  sequence s_rst_release;
    rst_rise ##1 !rst_held_reg;
  endsequence
  sequence s_wr_pdown;
    wr_evt && wr_hold_reg.pdown;
  endsequence

  property p_rst_short;
    !rst_held_reg && rlow_cnt_reg < RST_MIN |=> state_reg == $past(state_reg) || state_reg == mmc_pkg::ST_READY;
  endproperty
  a_rst_short: assert property (p_rst_short) else $error("short reset pulse restarted init");

  property p_rst_restart;
    s_rst_release |-> o_data_not_ready && !init_seen_reg;
  endproperty
  a_rst_restart: assert property (p_rst_restart) else $error("reset release did not restart init");

  property p_init_irq;
    init_done |=> !o_data_not_ready && flags_reg[`MMC_FLAG_INIT] ##1 !o_interrupt_n;
  endproperty
  a_init_irq: assert property (p_init_irq) else $error("init end without ready flag and interrupt");

  property p_ff_cause;
    $rose(init_seen_reg) |-> $past(flags_reg[`MMC_FLAG_INIT]) && !$past(o_interrupt_n);
  endproperty
  a_ff_cause: assert property (p_ff_cause) else $error("functional without ready interrupt");

  property p_lp_enter;
    lp_s |=> o_power_level1 && !o_fully_functional;
  endproperty
  a_lp_enter: assert property (p_lp_enter) else $error("low power pin not honoured");

  property p_pdown;
    s_wr_pdown |=> ##1 o_power_level1;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down override not honoured");

  property p_wake;
    $fell(pwr_low_reg) |-> !o_fully_functional;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without settle time");

  // a held reset or a mask write in the same cycle may legally cancel the interrupt
  property p_set_irq;
    !rst_held_reg && !wr_evt && |((flag_set & ~flag_clr) & irq_en) |=> flags_reg != '0 ##1 !o_interrupt_n;
  endproperty
  a_set_irq: assert property (p_set_irq) else $error("condition did not raise interrupt");

  property p_hold;
    irq_any |=> !o_interrupt_n;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped with flag set");

  property p_release;
    !irq_any |=> o_interrupt_n;
  endproperty
  a_release: assert property (p_release) else $error("interrupt not released");

  property p_clear;
    rd_evt && !rst_held_reg |=> (flags_reg & rd_hold_reg & ~$past(flag_set)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clearing read left flag set");

  property p_write;
    wr_evt |=> o_mask == $past(wr_hold_reg.mask) && o_rate_sel == $past(wr_hold_reg.rate_sel);
  endproperty
  a_write: assert property (p_write) else $error("write not applied");

  // a clearing read that leaves no unmasked flag must free the line two edges on
  sequence s_rd_clears_all;
    rd_evt && !rst_held_reg && !wr_evt && flag_set == '0 && (flags_reg & ~rd_hold_reg & irq_en) == '0;
  endsequence
  property p_rd_release;
    s_rd_clears_all |=> ##1 o_interrupt_n;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("interrupt not freed after clearing read");

  // a stalled initialisation must not count down at all
  property p_init_pause;
    state_reg == mmc_pkg::ST_INIT && init_stall && init_cnt_reg != '0 && !rst_held_reg |=> $stable(init_cnt_reg);
  endproperty
  a_init_pause: assert property (p_init_pause) else $error("init timer ran while held in low power");
endmodule
`default_nettype wire
